// *** bench/flash_model.sv ***
// behavioural model of the parallel nor flash beside the host controller
// assumes the bench resolves the data wire and inverts the busy output into ready/busy
`timescale 1ns/1ps

module flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h005a, // arbitrary value
  parameter logic [15:0] PROT = 16'h8000, // only the top sector is locked
  parameter int PROT_PROG_NS = 2000,
  parameter int PROT_ERASE_NS = 100000,
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 8000
) (
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic rb_low_out
);
  logic [15:0] mem [0:255];
  logic [15:0] la, pd, drv;
  logic bm, busy, susp, idm, lim, tog, chip;
  logic [3:0] es;
  int step, kind;

  // 16 words kept per sector, sector from the top nibble
  function automatic logic [7:0] ix(logic [15:0] a);
    return {a[15:12], a[3:0]};
  endfunction

  // --------------------------------------------------
  // read side
  // --------------------------------------------------
  function automatic logic [15:0] rdv(logic [15:0] a);
    // no add-sector window here, so the timer flag reads 1 as soon as erase runs
    if (busy) return {8'h00, kind == 1 ? ~pd[7] : 1'b0, tog, lim, 1'b0, kind == 2, 3'h0};
    if (susp && a[15:12] == es) return {8'h00, 1'b1, tog, 6'h00};
    if (idm && a[7:0] == 8'h00) return MAKER_CODE;
    if (idm && a[7:0] == (bm ? 8'h04 : 8'h02)) return {15'h0000, PROT[a[15:12]]};
    return mem[ix(a)];
  endfunction

  // value picked at the strobe fall and held, so the host sees it steady
  always @(negedge (oe_n_in | ce_n_in)) begin
    if (busy) tog = ~tog;
    drv = rdv(addr_in);
  end
  // a released bus shows the inverse, never a stale copy
  assign dq_out = (oe_n_in | ce_n_in) ? ~drv : drv;
  assign rb_low_out = busy;

  // --------------------------------------------------
  // write side
  // --------------------------------------------------
  // address at the later fall, data at the earlier rise
  always @(negedge (we_n_in | ce_n_in)) la = addr_in;
  always @(posedge (we_n_in | ce_n_in)) if (oe_n_in === 1'b1) wr(la, dq_in);

  task automatic prog(logic [15:0] a, logic [15:0] v);
    fork
      if (PROT[a[15:12]]) #PROT_PROG_NS busy = 0;
      else if ((v & ~mem[ix(a)]) != 0) #500 lim = 1;
      else begin
        #PROG_NS mem[ix(a)] = v;
        busy = 0;
      end
    join_none
  endtask

  task automatic erase(logic c, logic [3:0] s);
    chip = c;
    es = s;
    kind = 2;
    busy = 1;
    fork begin
      if (!c && PROT[s]) #PROT_ERASE_NS;
      else repeat (ERASE_NS / 200) begin
        #200;
        wait (!susp);
      end
      for (int i = 0; i < 256; i++) if ((c || i[7:4] == s) && !PROT[i[7:4]]) mem[i] = 16'hffff;
      busy = 0;
    end join_none
  endtask

  task automatic wr(logic [15:0] a, logic [15:0] dw);
    logic [7:0] d;
    logic [15:0] u1, u2;
    d = dw[7:0];
    u1 = bm ? 16'haaaa : 16'h5555;
    u2 = bm ? 16'h5555 : 16'h2aaa;
    if (d == 8'hf0 && (lim || !busy)) begin
      step = 0;
      {idm, lim, busy} = 3'b000;
    end else if (busy) begin
      if (d == 8'hb0 && kind == 2 && !chip) {susp, busy} = 2'b10;
    end else if (susp && step == 0 && d == 8'h30) begin
      {susp, busy} = 2'b01;
      kind = 2;
    end else begin
      case (step)
        0: if (d == 8'haa && (a == 16'h5555 || a == 16'haaaa)) begin
          bm = a[15];
          step = 1;
        end
        1: step = (a == u2 && d == 8'h55) ? 2 : 0;
        2: begin
          step = 0;
          if (a == u1 && d == 8'h90) idm = 1;
          if (a == u1 && d == 8'ha0) step = 3;
          if (a == u1 && d == 8'h80) step = 4;
        end
        3: begin
          step = 0;
          pd = dw;
          kind = 1;
          busy = 1;
          prog(a, dw);
        end
        4: step = (a == u1 && d == 8'haa) ? 5 : 0;
        5: step = (a == u2 && d == 8'h55) ? 6 : 0;
        default: begin
          step = 0;
          if (a == u1 && d == 8'h10) erase(1'b1, 4'h0);
          else if (d == 8'h30) erase(1'b0, a[15:12]);
        end
      endcase
    end
  endtask

  // erased-looking contents except the high byte, so programs can clear bits
  initial begin
    foreach (mem[i]) mem[i] = 16'h00ff;
    {bm, busy, susp, idm, lim, tog, chip} = '0;
    {step, kind, drv} = '0;
  end
endmodule

// *** bench/test_flash_host_ctrl.sv ***
// self-checking bench for the apb flash host controller
// assumes the flash model file is compiled before this one
`timescale 1ns/1ps
`include "flash_host_consts.svh"

module test_flash_host_ctrl;
  logic clk, rst, psel, penable, pwrite, err, rb_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  int n_fail, checks;
  wire [31:0] prdata;
  wire pready, pslverr, dq_oe, ce_n, we_n, oe_n, rb_low;
  wire [15:0] fa, dq_h, dq_m, dq;
  // wire level: host drives while enabled, else the flash
  assign dq = dq_oe ? dq_h : dq_m;

  flash_host_ctrl dut (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FL_ADDR_OUT(fa), .FL_DQ_IN(dq),
    .FL_DQ_OUT(dq_h), .FL_DQ_OE_OUT(dq_oe), .FL_CE_N_OUT(ce_n), .FL_WE_N_OUT(we_n),
    .FL_OE_N_OUT(oe_n), .READY_BUSY_IN(!rb_low));
  flash_model mdl (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(fa),
    .dq_in(dq), .dq_out(dq_m), .rb_low_out(rb_low));

  // --------------------------------------------------
  // bus and compare tasks
  // --------------------------------------------------
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge rb_low) rb_seen = 1;

  // one edge first, so psel never changes twice in a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // ctrl: [9] no poll, [8] byte mode, [3:0] order; ends with status in q
  task automatic order(input logic [15:0] a, input logic [15:0] v, input logic [9:0] c);
    apb(1, `REG_ADDR, {16'h0, a});
    apb(1, `REG_WDATA, {16'h0, v});
    rb_seen = 0;
    apb(1, `REG_CTRL, {22'h0, c} | 32'h10);
    repeat (4000) begin
      apb(0, `REG_STATUS, 0);
      if (q[0] === 1'b0) break;
    end
    chk("order ended", 0, q[0]);
  endtask

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic s_prog;
    apb(0, `REG_STATUS, 0);
    chk("idle status", 32'h10, q);
    apb(0, 8'h20, 0);
    chk("unmapped error", 1, err);
    order(16'h1003, 16'h0035, 10'h003);
    chk("status", 32'h12, q);
    chk("busy pin", 1, rb_seen);
    apb(0, `REG_RDATA, 0);
    chk("rdata", 32'h35, q);
    chk("word cell", 16'h0035, mdl.mem[8'h13]);
    order(16'h2004, 16'h0011, 10'h103);
    chk("byte cell", 16'h0011, mdl.mem[8'h24]);
    order(16'h1003, 16'h0000, 10'h000);
    apb(0, `REG_RDATA, 0);
    chk("array read", 32'h35, q);
  endtask

  // identification, then the reset order leaves it
  task automatic s_id;
    order(16'h0000, 16'h0000, 10'h002);
    apb(0, `REG_RDATA, 0);
    chk("maker", {16'h0, mdl.MAKER_CODE}, q);
    order(16'hf002, 16'h0000, 10'h002);
    apb(0, `REG_RDATA, 0);
    chk("protect bit", 1, q);
    order(16'h0000, 16'h0000, 10'h001);
    chk("id left", 0, mdl.idm);
  endtask

  // a one over a zero overruns the flash limit
  task automatic s_fail;
    order(16'h3005, 16'h0135, 10'h003);
    chk("fail bit", 1, q[2]);
    chk("limit reset", 0, mdl.lim);
    chk("cell kept", 16'h00ff, mdl.mem[8'h35]);
    // a locked sector: status ends done with no failure, and the cell keeps its old value
    order(16'hf001, 16'h0081, 10'h003);
    chk("protect status", 32'h12, q);
    chk("protected cell", 16'h00ff, mdl.mem[8'hf1]);
  endtask

  task automatic s_erase;
    order(16'h1000, 16'h0000, 10'h005);
    chk("erased", 16'hffff, mdl.mem[8'h13]);
    chk("other sector", 16'h0011, mdl.mem[8'h24]);
    order(16'h2000, 16'h0000, 10'h205);
    order(16'h2000, 16'h0000, 10'h006);
    chk("suspended", 1, mdl.susp);
    order(16'h3006, 16'h0005, 10'h003);
    chk("suspend program", 16'h0005, mdl.mem[8'h36]);
    order(16'h0000, 16'h0000, 10'h007);
    chk("resumed", 0, mdl.susp);
    repeat (3000) begin
      @(posedge clk);
      if (!mdl.busy) break;
    end
    chk("erase ended", 0, mdl.busy);
    chk("resumed erase", 16'hffff, mdl.mem[8'h24]);
    order(16'h3005, 16'h0000, 10'h004);
    chk("chip erased", 16'hffff, mdl.mem[8'h36]);
    chk("protected kept", 16'h00ff, mdl.mem[8'hf1]);
  endtask

  // --------------------------------------------------
  // run control
  // --------------------------------------------------
  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // the whole run needs some 5k cycles; this cuts a hang at 50k
  initial begin
    #400000;
    n_fail++;
    conclude;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rb_seen} = '0;
    {n_fail, checks} = '0;
    rst = 1;
    repeat (10) @(posedge clk);
    rst <= 0;
    s_prog;
    s_id;
    s_fail;
    s_erase;
    conclude;
  end
endmodule

// *** design/flash_cycle_engine.sv ***
// one read or write cycle on the flash pins
// assumes the data pins arrive unsynchronised from the flash
`timescale 1ns/1ps
`include "flash_host_consts.svh"

module flash_cycle_engine (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire flash_host_pkg::step_type step_in,
  input wire logic [15:0] dq_in,
  output flash_host_pkg::pins_type pins_out,
  output logic done_out,
  output logic [15:0] rdata_out
);
  import flash_host_pkg::*;

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_type;

  localparam logic [4:0] SETUP_CYC = 5'(`CYC_UP(`SETUP_NS));
  localparam logic [4:0] WE_CYC = 5'(`CYC_UP(`WE_PULSE_NS));
  // access time plus the synchroniser depth so the sample is settled
  localparam logic [4:0] RD_CYC = 5'(`CYC_UP(`ACCESS_NS) + `SYNC_CYC);
  localparam logic [4:0] HOLD_CYC = 5'(`CYC_UP(`HOLD_NS));

  eng_type state_r, state_nxt;
  step_type step_r, step_nxt;
  pins_type pins_r, pins_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] dq1_r, dq2_r, dq3_r;

  // ----------------------------------------
  // cycle sequencing
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    rdata_nxt = rdata_r;
    unique case (state_r)
      E_IDLE: if (start_in) begin
        step_nxt = step_in;
        cnt_nxt = SETUP_CYC - 5'h01;
        state_nxt = E_SETUP;
      end
      E_SETUP: if (cnt_r == 5'h00) begin
        cnt_nxt = step_r.rd ? RD_CYC - 5'h01 : WE_CYC - 5'h01;
        state_nxt = E_STROBE;
      end else begin
        cnt_nxt = cnt_r - 5'h01;
      end
      E_STROBE: if (cnt_r != 5'h00) begin
        cnt_nxt = cnt_r - 5'h01;
      end else if (!step_r.rd || dq2_r == dq3_r) begin
        // a changing bus stretches the read until two stages agree
        if (step_r.rd) rdata_nxt = dq3_r;
        cnt_nxt = HOLD_CYC - 5'h01;
        state_nxt = E_HOLD;
      end
      E_HOLD: if (cnt_r == 5'h00) begin
        state_nxt = E_IDLE;
      end else begin
        cnt_nxt = cnt_r - 5'h01;
      end
    endcase
    // pins follow the next state so they leave flops glitch free
    pins_nxt.addr = step_nxt.addr;
    pins_nxt.dq = step_nxt.data;
    pins_nxt.ce_n = (state_nxt == E_IDLE);
    pins_nxt.we_n = !(state_nxt == E_STROBE && !step_nxt.rd);
    pins_nxt.oe_n = !(state_nxt == E_STROBE && step_nxt.rd);
    // data stays driven past the write strobe rise, where it latches
    pins_nxt.dq_oe = (state_nxt != E_IDLE) && !step_nxt.rd;
  end

  // registers and pin synchroniser
  always_ff @(posedge clk_in) begin
    dq1_r <= dq_in;
    dq2_r <= dq1_r;
    dq3_r <= dq2_r;
    if (rst_in) begin
      state_r <= E_IDLE;
      step_r <= '0;
      cnt_r <= 5'h00;
      rdata_r <= 16'h0000;
      pins_r <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0, addr: 16'h0000, dq: 16'h0000};
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      rdata_r <= rdata_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign pins_out = pins_r;
  assign rdata_out = rdata_r;
  assign done_out = (state_r == E_HOLD) && (cnt_r == 5'h00);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  strobes_excl_a: assert property (@(posedge clk_in) disable iff (rst_in) !(!pins_r.we_n && !pins_r.oe_n))
    else $error("write and read strobes low together");
  we_in_ce_a: assert property (@(posedge clk_in) disable iff (rst_in) !pins_r.we_n |-> !pins_r.ce_n)
    else $error("write strobe without chip select");
  data_after_we_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(pins_r.we_n) |-> pins_r.dq_oe && $stable(pins_r.dq))
    else $error("write data released with the strobe");
  we_width_a: assert property (@(posedge clk_in) disable iff (rst_in) $fell(pins_r.we_n) |-> !pins_r.we_n[*5])
    else $error("write strobe too short");
  addr_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !pins_r.ce_n && $past(!pins_r.ce_n) |-> $stable(pins_r.addr))
    else $error("address moved inside a cycle");
endmodule

// *** design/flash_host_consts.svh ***
// constants for the parallel flash host controller
// assumes a 125 MHz system clock and a flash with 70 ns access
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define ACCESS_NS 70
`define WE_PULSE_NS 40
`define SETUP_NS 10
`define HOLD_NS 10
`define SYNC_CYC 3
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// apb register map and fields
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0c
`define REG_RDATA 8'h10
`define CTRL_START_BIT 4
`define CTRL_BYTE_BIT 8
`define CTRL_NOPOLL_BIT 9

// ----------------------------------------
// flash bus codes and status bits
// ----------------------------------------
`define UNLOCK_W1 16'h5555
`define UNLOCK_W2 16'h2aaa
`define UNLOCK_B1 16'haaaa
`define UNLOCK_B2 16'h5555
`define CODE_AA 8'haa
`define CODE_55 8'h55
`define CODE_ID 8'h90
`define CODE_PROG 8'ha0
`define CODE_ERASE 8'h80
`define CODE_CHIP 8'h10
`define CODE_SECT 8'h30
`define CODE_SUSP 8'hb0
`define CODE_RESET 8'hf0
`define POLL_BIT 7
`define LIMIT_BIT 5

`endif

// *** design/flash_host_ctrl.sv ***
// apb-programmed host controller for a parallel nor flash
// assumes software waits for busy to fall before a new order
`timescale 1ns/1ps
`include "flash_host_consts.svh"

// Function
// - plain read order is one read cycle, no unlock writes
// - reset order writes f0 once; also sent after a timing-limit failure
// - unlock writes aa then 55 at word or byte unlock addresses
// - identification: two unlocks, 90, then a read at the given offset
// - program: two unlocks, a0, then value at the target location
// - chip erase: unlocks, 80, unlocks, 10 to first unlock address
// - sector erase: same five writes, then 30 at the sector address
// - suspend is one b0 write at any address
// - resume is one 30 write at any address
// - erase polling bit reads 0 then 1; poll inside an erased sector
// - after polling bit turns true, result comes from a further read
module flash_host_ctrl (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [15:0] FL_ADDR_OUT,
  input wire logic [15:0] FL_DQ_IN,
  output logic [15:0] FL_DQ_OUT,
  output logic FL_DQ_OE_OUT,
  output logic FL_CE_N_OUT,
  output logic FL_WE_N_OUT,
  output logic FL_OE_N_OUT,
  input wire logic READY_BUSY_IN
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_SEQ, S_POLL, S_FINAL, S_RST} seq_type;

  // ----------------------------------------
  // command step table
  // ----------------------------------------
  function automatic step_type step_of(cmd_type c, logic [2:0] i, logic byt,
                                       logic [15:0] a, logic [15:0] d);
    logic [15:0] u1;
    logic [15:0] u2;
    step_type s;
    u1 = byt ? `UNLOCK_B1 : `UNLOCK_W1;
    u2 = byt ? `UNLOCK_B2 : `UNLOCK_W2;
    // single writes carry a zero upper byte; the flash ignores it
    s = '{last: 1'b1, rd: 1'b0, addr: a, data: {8'h00, `CODE_RESET}};
    unique case (c)
      CMD_READ: s.rd = 1'b1;
      CMD_SUSPEND: s.data[7:0] = `CODE_SUSP;
      CMD_RESUME, CMD_ADD_SECT: s.data[7:0] = `CODE_SECT;
      CMD_ID, CMD_PROG, CMD_CHIP, CMD_SECT: begin
        s.last = 1'b0;
        unique case (i)
          3'h0, 3'h3: begin
            s.addr = u1;
            s.data[7:0] = `CODE_AA;
          end
          3'h1, 3'h4: begin
            s.addr = u2;
            s.data[7:0] = `CODE_55;
          end
          3'h2: begin
            s.addr = u1;
            s.data[7:0] = (c == CMD_ID) ? `CODE_ID : (c == CMD_PROG) ? `CODE_PROG : `CODE_ERASE;
          end
          default: begin
            s.last = 1'b1;
            s.addr = (c == CMD_CHIP) ? u1 : a;
            s.data[7:0] = (c == CMD_CHIP) ? `CODE_CHIP : `CODE_SECT;
          end
        endcase
        if (i == 3'h3 && c == CMD_ID) begin
          s = '{last: 1'b1, rd: 1'b1, addr: a, data: 16'h0000};
        end else if (i == 3'h3 && c == CMD_PROG) begin
          s = '{last: 1'b1, rd: 1'b0, addr: a, data: d};
        end
      end
      default: ;
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  seq_type state_r, state_nxt;
  cmd_type cmd_r, cmd_nxt;
  logic byte_r, byte_nxt;
  logic nopoll_r, nopoll_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic fail_r, fail_nxt;
  logic recheck_r, recheck_nxt;
  logic wait_r, wait_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic rb1_r, rb2_r, rb3_r, rb_r, rb_nxt;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;

  logic wr_en, start_ord, eng_start, eng_done, poll_hit, polled;
  logic [15:0] eng_rdata;
  step_type cur_step, eng_step;
  pins_type pins;

  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign start_ord = wr_en && PADDR_IN == `REG_CTRL && PWDATA_IN[`CTRL_START_BIT] && state_r == S_IDLE;
  assign cur_step = step_of(cmd_r, idx_r, byte_r, addr_r, wdata_r);
  assign polled = !nopoll_r && (cmd_r == CMD_PROG || cmd_r == CMD_CHIP || cmd_r == CMD_SECT ||
                                cmd_r == CMD_SUSPEND);
  // program polls for the true written bit, erase and suspend for a one
  assign poll_hit = eng_rdata[`POLL_BIT] == ((cmd_r == CMD_PROG) ? wdata_r[`POLL_BIT] : 1'b1);
  assign eng_start = (state_r != S_IDLE) && !wait_r;

  // step sent to the pin engine in each phase
  always_comb begin
    eng_step = cur_step;
    unique case (state_r)
      S_POLL, S_FINAL: eng_step = '{last: 1'b1, rd: 1'b1, addr: addr_r, data: 16'h0000};
      S_RST: eng_step = '{last: 1'b1, rd: 1'b0, addr: addr_r, data: {8'h00, `CODE_RESET}};
      default: ;
    endcase
  end

  // ----------------------------------------
  // sequencer and registers
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    byte_nxt = byte_r;
    nopoll_nxt = nopoll_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    recheck_nxt = recheck_r;
    wait_nxt = wait_r;
    idx_nxt = idx_r;
    // orders and operands are frozen while a sequence runs
    if (wr_en && state_r == S_IDLE) begin
      unique case (PADDR_IN)
        `REG_CTRL: begin
          cmd_nxt = cmd_type'(PWDATA_IN[3:0]);
          byte_nxt = PWDATA_IN[`CTRL_BYTE_BIT];
          nopoll_nxt = PWDATA_IN[`CTRL_NOPOLL_BIT];
        end
        `REG_ADDR: addr_nxt = PWDATA_IN[15:0];
        `REG_WDATA: wdata_nxt = PWDATA_IN[15:0];
        default: ;
      endcase
    end
    if (eng_start) wait_nxt = 1'b1;
    unique case (state_r)
      S_IDLE: if (start_ord) begin
        state_nxt = S_SEQ;
        idx_nxt = 3'h0;
        wait_nxt = 1'b0;
        done_nxt = 1'b0;
        fail_nxt = 1'b0;
        recheck_nxt = 1'b0;
      end
      S_SEQ: if (eng_done) begin
        wait_nxt = 1'b0;
        idx_nxt = idx_r + 3'h1;
        if (cur_step.last) begin
          if (cur_step.rd) rdata_nxt = eng_rdata;
          state_nxt = polled ? S_POLL : S_IDLE;
          done_nxt = !polled;
        end
      end
      S_POLL: if (eng_done) begin
        wait_nxt = 1'b0;
        rdata_nxt = eng_rdata;
        if (poll_hit) begin
          state_nxt = S_FINAL;
        end else if (recheck_r) begin
          fail_nxt = 1'b1;
          state_nxt = S_RST;
        end else if (eng_rdata[`LIMIT_BIT]) begin
          // polling may flip together with the limit flag, so look once more
          recheck_nxt = 1'b1;
        end
      end
      S_FINAL: if (eng_done) begin
        wait_nxt = 1'b0;
        rdata_nxt = eng_rdata;
        done_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      S_RST: if (eng_done) begin
        wait_nxt = 1'b0;
        done_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
    // ready/busy pin counts once two synchroniser stages agree
    rb_nxt = (rb2_r == rb3_r) ? rb3_r : rb_r;
  end

  // apb read data and error, taken in the access phase
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    unique case (PADDR_IN)
      `REG_CTRL: prdata_nxt = {22'h000000, nopoll_r, byte_r, 4'h0, 4'(cmd_r)};
      `REG_ADDR: prdata_nxt = {16'h0000, addr_r};
      `REG_WDATA: prdata_nxt = {16'h0000, wdata_r};
      `REG_STATUS: prdata_nxt = {27'h0000000, rb_r, recheck_r, fail_r, done_r, state_r != S_IDLE};
      `REG_RDATA: prdata_nxt = {16'h0000, rdata_r};
      default: pslverr_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    rb1_r <= READY_BUSY_IN;
    rb2_r <= rb1_r;
    rb3_r <= rb2_r;
    if (RST_IN) begin
      state_r <= S_IDLE;
      cmd_r <= CMD_READ;
      byte_r <= 1'b0;
      nopoll_r <= 1'b0;
      addr_r <= 16'h0000;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      recheck_r <= 1'b0;
      wait_r <= 1'b0;
      idx_r <= 3'h0;
      rb_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      byte_r <= byte_nxt;
      nopoll_r <= nopoll_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      recheck_r <= recheck_nxt;
      wait_r <= wait_nxt;
      idx_r <= idx_nxt;
      rb_r <= rb_nxt;
    end
  end

  // ----------------------------------------
  // pin engine and outputs
  // ----------------------------------------
  flash_cycle_engine eng (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .start_in(eng_start),
    .step_in(eng_step),
    .dq_in(FL_DQ_IN),
    .pins_out(pins),
    .done_out(eng_done),
    .rdata_out(eng_rdata)
  );

  assign FL_ADDR_OUT = pins.addr;
  assign FL_DQ_OUT = pins.dq;
  assign FL_DQ_OE_OUT = pins.dq_oe;
  assign FL_CE_N_OUT = pins.ce_n;
  assign FL_WE_N_OUT = pins.we_n;
  assign FL_OE_N_OUT = pins.oe_n;
  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = prdata_nxt;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && pslverr_nxt;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  apb_ready_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) PSEL_IN && PENABLE_IN |-> PREADY_OUT)
    else $error("apb access not answered");
  unlock_first_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    eng_start && state_r == S_SEQ && idx_r == 3'h0 && cmd_r inside {CMD_ID, CMD_PROG, CMD_CHIP, CMD_SECT}
    |-> eng_step.data[7:0] == `CODE_AA && eng_step.addr == (byte_r ? `UNLOCK_B1 : `UNLOCK_W1))
    else $error("sequence does not open with the first unlock");
  prog_code_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    eng_start && state_r == S_SEQ && idx_r == 3'h2 && cmd_r == CMD_PROG |-> eng_step.data == {8'h00, `CODE_PROG})
    else $error("program setup code wrong");
  chip_last_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    eng_start && state_r == S_SEQ && cmd_r == CMD_CHIP && eng_step.last
    |-> idx_r == 3'h5 && eng_step.data[7:0] == `CODE_CHIP)
    else $error("chip erase ends wrongly");
  reset_code_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    eng_start && (state_r == S_RST || (state_r == S_SEQ && cmd_r == CMD_RESET))
    |-> !eng_step.rd && eng_step.data == {8'h00, `CODE_RESET})
    else $error("reset write not f0");
  final_read_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_r == S_POLL && eng_done && poll_hit |=> state_r == S_FINAL && !done_r)
    else $error("result taken without a further read");
  fail_reset_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(fail_r) |-> state_r == S_RST ##[1:60] !pins.we_n && pins.dq[7:0] == `CODE_RESET)
    else $error("failure not followed by reset write");
endmodule

// *** design/flash_host_pkg.sv ***
// types shared by the flash host controller files
// assumes the constants header is compiled alongside
package flash_host_pkg;

  // ----------------------------------------
  // orders that software may give
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_READ, CMD_RESET, CMD_ID, CMD_PROG, CMD_CHIP, CMD_SECT,
    CMD_SUSPEND, CMD_RESUME, CMD_ADD_SECT
  } cmd_type;

  // one flash bus cycle
  typedef struct packed {
    logic last;
    logic rd;
    logic [15:0] addr;
    logic [15:0] data;
  } step_type;

  // flash pin levels driven by the host
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic [15:0] addr;
    logic [15:0] dq;
  } pins_type;

endpackage
